//--- ptk_pkg.sv
/*
  Constants shared by the periodic tick timer: register offsets, field positions,
  field widths and reset values.
  Assumes a 32-bit register port with byte addresses that are word aligned.
*/
`default_nettype none

package ptk_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned PTK_ADDR_W = 8;   // Register port address width
  localparam int unsigned PTK_DATA_W = 32;  // Register port data width
  localparam int unsigned PTK_CNT_W  = 24;  // Live count and wrap start width

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [PTK_ADDR_W-1:0] PTK_OFS_CTRL = 8'h00;  // Control and status
  localparam logic [PTK_ADDR_W-1:0] PTK_OFS_WRAP = 8'h04;  // wrap_start_value
  localparam logic [PTK_ADDR_W-1:0] PTK_OFS_LIVE = 8'h08;  // live_countdown

  // ****************************************************************
  // Control and status field positions
  // ****************************************************************
  localparam int unsigned PTK_BIT_ENABLE = 0;   // Counter runs while set
  localparam int unsigned PTK_BIT_TICKEN = 1;   // tick_irq_enable
  localparam int unsigned PTK_BIT_CLKSRC = 2;   // Clock source select, core clock only
  localparam int unsigned PTK_BIT_ZFLAG  = 16;  // zero_reached_flag

  // ****************************************************************
  // Reset and special values
  // ****************************************************************
  localparam logic [PTK_CNT_W-1:0]  PTK_CNT_ZERO  = 24'h000000;  // Live count at reset
  localparam logic [PTK_CNT_W-1:0]  PTK_CNT_ONE   = 24'h000001;  // Step that fires a tick
  localparam logic [PTK_CNT_W-1:0]  PTK_WRAP_RST  = 24'h000000;  // Wrap start at reset
  localparam logic [PTK_DATA_W-1:0] PTK_WORD_ZERO = 32'h00000000;  // Unmapped read value

endpackage : ptk_pkg

`default_nettype wire

//--- ptk_rst_sync.sv
/*
  Reset release synchroniser for the periodic tick timer.
  Assumes nrst may drop at any time; release is aligned to clock.
*/
`timescale 1ns/10ps
`default_nettype none

module ptk_rst_sync (
  // Clock and raw reset
  input  wire logic clock,
  input  wire logic nrst,
  // Synchronised reset, active low
  output var  logic rst_n
);

  logic stage1_n;  // First stage, read only by the second

  // Assert at once, release after two edges so no flop sees a runt release
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stage1_n <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      stage1_n <= 1'b1;
      rst_n    <= stage1_n;
    end
  end

endmodule // ptk_rst_sync

`default_nettype wire

//--- ptk_timer.sv
/*
  Periodic tick timer: 24-bit down counter with wrap start value, live count,
  sticky zero flag and a tick pend pulse toward the interrupt controller.
  Assumes a single core clock, a plain register port with read data one cycle
  after the read strobe, and a core halt level from logic on the same clock.
*/
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module ptk_timer
  import ptk_pkg::*;
(
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         nrst,
  // Register port
  input  wire logic [ptk_pkg::PTK_ADDR_W-1:0] addr,
  input  wire logic [ptk_pkg::PTK_DATA_W-1:0] wr_data,
  input  wire logic                         wr_en,
  input  wire logic                         rd_en,
  output var  logic [ptk_pkg::PTK_DATA_W-1:0] rd_data,
  // Core status
  input  wire logic                         core_halted,
  // Tick toward the interrupt controller
  output var  logic                         tick_pend
);

  import ptk_pkg::*;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_n;  // Synchronised reset used by all state below

  ptk_rst_sync u_rst_sync (
    .clock (clock),
    .nrst  (nrst),
    .rst_n (rst_n)
  );

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic wr_ctrl;  // Write to control and status
  logic wr_wrap;  // Write to wrap start
  logic wr_live;  // Write to live count
  logic rd_ctrl;  // Read of control and status

  // Decoded strobes; no calibration offset exists, so it reads as unmapped
  assign wr_ctrl = wr_en && (addr == PTK_OFS_CTRL);
  assign wr_wrap = wr_en && (addr == PTK_OFS_WRAP);
  assign wr_live = wr_en && (addr == PTK_OFS_LIVE);
  assign rd_ctrl = rd_en && (addr == PTK_OFS_CTRL);

  // ****************************************************************
  // Control bits and wrap start
  // ****************************************************************
  logic                 ctrl_enable;       // Counter runs while set
  logic                 tick_irq_enable;   // Pend a tick at each step from one to zero
  logic                 ctrl_clksrc;       // Stored only; the core clock is the source
  logic [PTK_CNT_W-1:0] wrap_start;        // Value loaded at each zero
  logic                 next_ctrl_enable;  // Next enable
  logic                 next_tick_irq_enable;  // Next tick enable
  logic                 next_ctrl_clksrc;  // Next clock source bit
  logic [PTK_CNT_W-1:0] next_wrap_start;   // Next wrap start

  // Next values of the software fields
  always_comb begin
    next_ctrl_enable     = ctrl_enable;
    next_tick_irq_enable = tick_irq_enable;
    next_ctrl_clksrc     = ctrl_clksrc;
    next_wrap_start      = wrap_start;
    // Control write: only the three writable bits, the flag is not writable
    if (wr_ctrl) begin
      next_ctrl_enable     = wr_data[PTK_BIT_ENABLE];
      next_tick_irq_enable = wr_data[PTK_BIT_TICKEN];
      next_ctrl_clksrc     = wr_data[PTK_BIT_CLKSRC];
    end
    // Wrap write: upper reserved bits are dropped
    if (wr_wrap) begin
      next_wrap_start = wr_data[PTK_CNT_W-1:0];
    end
  end

  // Register the software fields
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_enable     <= 1'b0;
      tick_irq_enable <= 1'b0;
      ctrl_clksrc     <= 1'b0;
      wrap_start      <= PTK_WRAP_RST;
    end else begin
      ctrl_enable     <= next_ctrl_enable;
      tick_irq_enable <= next_tick_irq_enable;
      ctrl_clksrc     <= next_ctrl_clksrc;
      wrap_start      <= next_wrap_start;
    end
  end

  // ****************************************************************
  // Down counter, zero flag and tick
  // ****************************************************************
  logic [PTK_CNT_W-1:0] live_count;       // Live countdown value
  logic                 zero_reached_flag;  // Sticky zero flag
  logic [PTK_CNT_W-1:0] next_live_count;  // Next live count
  logic                 next_zero_reached_flag;  // Next zero flag
  logic                 next_tick_pend;   // Next tick pulse
  logic                 run;              // Counter advances this cycle
  logic                 hit;              // Step from one to zero this cycle

  // A halted core freezes the count so a debugger sees a steady value
  assign run = ctrl_enable && !core_halted;
  // Only the step from one fires; a zero wrap start never reaches one
  assign hit = run && (live_count == PTK_CNT_ONE);

  // Next count, flag and tick
  always_comb begin
    next_live_count        = live_count;
    next_zero_reached_flag = zero_reached_flag;
    next_tick_pend         = 1'b0;
    // Advance: reload at zero, otherwise step down
    if (run) begin
      if (live_count == PTK_CNT_ZERO) begin
        next_live_count = wrap_start;
      end else begin
        next_live_count = live_count - PTK_CNT_ONE;
      end
    end
    // Live count write clears count and flag whatever the data
    if (wr_live) begin
      next_live_count        = PTK_CNT_ZERO;
      next_zero_reached_flag = 1'b0;
    end
    // Reading the status consumes the flag
    if (rd_ctrl) begin
      next_zero_reached_flag = 1'b0;
    end
    // A zero arriving with a clear wins, so no event is ever lost
    if (hit) begin
      next_zero_reached_flag = 1'b1;
      next_tick_pend         = tick_irq_enable;
    end
  end

  // Register count, flag and tick
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      live_count        <= PTK_CNT_ZERO;
      zero_reached_flag <= 1'b0;
      tick_pend         <= 1'b0;
    end else begin
      live_count        <= next_live_count;
      zero_reached_flag <= next_zero_reached_flag;
      tick_pend         <= next_tick_pend;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [PTK_DATA_W-1:0] next_rd_data;  // Next read word

  // Read mux; reserved and unmapped bits read as zero
  always_comb begin
    next_rd_data = PTK_WORD_ZERO;
    if (rd_en) begin
      unique case (addr)
        PTK_OFS_CTRL: begin
          next_rd_data[PTK_BIT_ENABLE] = ctrl_enable;
          next_rd_data[PTK_BIT_TICKEN] = tick_irq_enable;
          next_rd_data[PTK_BIT_CLKSRC] = ctrl_clksrc;
          next_rd_data[PTK_BIT_ZFLAG]  = zero_reached_flag;
        end
        PTK_OFS_WRAP: begin
          next_rd_data[PTK_CNT_W-1:0] = wrap_start;
        end
        PTK_OFS_LIVE: begin
          next_rd_data[PTK_CNT_W-1:0] = live_count;
        end
        default: begin
          next_rd_data = PTK_WORD_ZERO;
        end
      endcase
    end
  end

  // Read data stands for one cycle only, zero otherwise
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= PTK_WORD_ZERO;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Count at one while running and untouched by software
  sequence s_at_one;
    run && (live_count == PTK_CNT_ONE) && !wr_live;
  endsequence

  // Next cycle: at zero with the flag up
  sequence s_reached_zero;
    (live_count == PTK_CNT_ZERO) && zero_reached_flag;
  endsequence

  // The step from one always leaves zero and a raised flag behind
  a_step_sets_flag: assert property (s_at_one |=> s_reached_zero)
    else $error("Step to zero did not set the flag");

  // An enabled tick follows the step to zero by exactly one edge
  a_tick_when_enabled: assert property (
    (hit && tick_irq_enable) |=> tick_pend)
    else $error("Tick not pended on zero with enable set");

  // No tick without a step from one while enabled and running
  a_tick_has_cause: assert property (
    tick_pend |-> ($past(live_count) == PTK_CNT_ONE) && $past(tick_irq_enable)
      && $past(run))
    else $error("Tick pended without a step to zero");

  // With tick enable clear the pend line stays low whatever the count does
  a_tick_gated_off: assert property (
    !tick_irq_enable |=> !tick_pend)
    else $error("Tick pended with tick enable clear");

  // Zero is a reload step, never a second tick
  a_reload_at_zero: assert property (
    (run && (live_count == PTK_CNT_ZERO) && !wr_live)
      |=> (live_count == $past(wrap_start)) && !tick_pend)
    else $error("Counter did not reload from wrap start");

  // Wrap start one: the step from one comes back two cycles later
  a_period_two: assert property (
    (s_at_one ##1 (run && !wr_live && !wr_wrap && wrap_start == PTK_CNT_ONE)
      ##1 (run && !wr_live)) |=> tick_pend == $past(tick_irq_enable))
    else $error("Wrap start one did not tick every two cycles");

  // A live write empties the count; only a coinciding step keeps the flag
  a_live_write_clears: assert property (
    wr_live |=> (live_count == PTK_CNT_ZERO)
      && (zero_reached_flag == $past(hit)))
    else $error("Live count write did not clear count and flag");

  // Reading the status consumes the flag unless a new zero arrives
  a_flag_read_clear: assert property (
    (rd_ctrl && !hit) |=> !zero_reached_flag)
    else $error("Status read did not clear the flag");

  // The status read returns the flag and enable as they stood when read
  a_status_read_value: assert property (
    rd_ctrl |=> (rd_data[PTK_BIT_ZFLAG] == $past(zero_reached_flag))
      && (rd_data[PTK_BIT_ENABLE] == $past(ctrl_enable)))
    else $error("Status read returned wrong flag or enable");

  // A halted core sees a steady count and no tick
  a_halt_freezes: assert property (
    (core_halted && !wr_live) |=> $stable(live_count) && !tick_pend)
    else $error("Counter moved while core halted");

  // Live read returns the count of the read cycle, upper byte zero
  a_live_read_value: assert property (
    (rd_en && addr == PTK_OFS_LIVE) |=>
      (rd_data == {8'h00, $past(live_count)}))
    else $error("Live count read returned wrong value");

  // Wrap read shows the stored field with the reserved byte at zero
  a_wrap_read_value: assert property (
    (rd_en && addr == PTK_OFS_WRAP) |=>
      (rd_data == {8'h00, $past(wrap_start)}))
    else $error("Wrap read returned wrong value");

  // Reserved upper bits of a wrap write are dropped
  a_wrap_low_only: assert property (
    wr_wrap |=> wrap_start == $past(wr_data[PTK_CNT_W-1:0]))
    else $error("Wrap write stored wrong bits");

  // A zero wrap start keeps the counter parked at zero, silent
  a_zero_wrap_silent: assert property (
    ((wrap_start == PTK_CNT_ZERO) && (live_count == PTK_CNT_ZERO) && !wr_wrap)
      |=> !tick_pend && (live_count == PTK_CNT_ZERO))
    else $error("Zero wrap start produced activity");

endmodule // ptk_timer

`default_nettype wire

//--- tb.sv
/*
  Self-checking testbench for the periodic tick timer: register table rows,
  then hand-written tests of tick timing, halt, flag clearing and reset.
  Assumes the ptk_pkg constants and a 250 MHz core clock.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  import ptk_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic                  clock       = 1'b0;   // Core clock
  logic                  nrst        = 1'b0;   // Raw reset, active low
  logic [PTK_ADDR_W-1:0] addr        = 8'h00;  // Register address
  logic [PTK_DATA_W-1:0] wr_data     = 32'h0;  // Write data
  logic                  wr_en       = 1'b0;   // Write strobe
  logic                  rd_en       = 1'b0;   // Read strobe
  logic [PTK_DATA_W-1:0] rd_data;              // Read data
  logic                  core_halted = 1'b0;   // Debug halt level
  logic                  tick_pend;            // Tick pulse
  int                    error_cnt   = 0;      // Mismatches seen
  int                    compares    = 0;      // Comparisons made
  int                    tick_cnt    = 0;      // Tick pulses seen
  int                    n;                    // Cycle counter
  logic [PTK_DATA_W-1:0] v;                    // Read result
  logic [PTK_DATA_W-1:0] v1;                   // Earlier read result

  // Register rows: write one place, read one place, expected read
  typedef struct {
    logic [PTK_ADDR_W-1:0] wa;
    logic [PTK_DATA_W-1:0] wd;
    logic [PTK_ADDR_W-1:0] ra;
    logic [PTK_DATA_W-1:0] ex;
  } ptk_row_t;
  ptk_row_t rows [6] = '{
    '{PTK_OFS_WRAP, 32'hFFFFFFFF, PTK_OFS_WRAP, 32'h00FFFFFF},
    '{PTK_OFS_WRAP, 32'h12345678, PTK_OFS_WRAP, 32'h00345678},
    '{PTK_OFS_LIVE, 32'hFFFFFFFF, PTK_OFS_LIVE, 32'h00000000},
    '{8'h0C,        32'h00001234, 8'h0C,        32'h00000000},
    '{PTK_OFS_CTRL, 32'h00000006, PTK_OFS_CTRL, 32'h00000006},
    '{PTK_OFS_CTRL, 32'h00000000, PTK_OFS_CTRL, 32'h00000000}
  };

  ptk_timer dut (
    .clock(clock), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .core_halted(core_halted), .tick_pend(tick_pend)
  );

  // ****************************************************************
  // Clock, tick monitor and tasks
  // ****************************************************************
  // 4 ns period
  always #2 clock = ~clock;

  // Count tick pulses so quiet windows can be checked
  always @(posedge clock) begin
    if (tick_pend === 1'b1) begin
      tick_cnt++;
    end
  end

  task automatic check(input logic [PTK_DATA_W-1:0] seen, input logic [PTK_DATA_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [PTK_ADDR_W-1:0] a, input logic [PTK_DATA_W-1:0] d);
    @(posedge clock);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clock);
    wr_en   <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle only
  task automatic rd(input logic [PTK_ADDR_W-1:0] a, output logic [PTK_DATA_W-1:0] d);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic set_halt(input logic h);
    @(posedge clock);
    core_halted <= h;
  endtask

  // Cycles until the next tick pulse, bounded so a dead counter cannot hang
  task automatic to_tick(output int c);
    c = 0;
    do begin
      @(posedge clock);
      #1 c++;
    end while (tick_pend !== 1'b1 && c < 100);
  endtask

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
  endtask

  task automatic print_verdict();
    $display("Compared %0d values, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #(20000 * 4);
    error_cnt++;
    print_verdict();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra, v);
      check(v, rows[i].ex);
    end
    // Frozen setup: wrap 3, count cleared, tick enabled
    set_halt(1'b1);
    wr(PTK_OFS_WRAP, 32'h00000003);
    wr(PTK_OFS_LIVE, 32'h00000000);
    wr(PTK_OFS_CTRL, 32'h00000003);
    set_halt(1'b0);
    to_tick(n);
    check(n, 4);
    to_tick(n);
    check(n, 4);
    // Halted: count frozen and no tick
    set_halt(1'b1);
    rd(PTK_OFS_LIVE, v1);
    n = tick_cnt;
    repeat (10) @(posedge clock);
    rd(PTK_OFS_LIVE, v);
    check(v, v1);
    check(tick_cnt, n);
    // Live write clears the pending flag as well
    wr(PTK_OFS_LIVE, 32'hA5A5A5A5);
    rd(PTK_OFS_CTRL, v);
    check(v, 32'h00000003);
    // Two steps from zero: reload to 3, then 2
    set_halt(1'b0);
    repeat (2) @(posedge clock);
    core_halted <= 1'b1;
    rd(PTK_OFS_LIVE, v);
    check(v, 32'h00000002);
    // Tick enable off: flag still set, no pulse, flag clears on read
    wr(PTK_OFS_CTRL, 32'h00000001);
    n = tick_cnt;
    set_halt(1'b0);
    repeat (20) @(posedge clock);
    core_halted <= 1'b1;
    check(tick_cnt, n);
    rd(PTK_OFS_CTRL, v);
    check(v, 32'h00010001);
    rd(PTK_OFS_CTRL, v);
    check(v, 32'h00000001);
    // Zero wrap: no tick and no flag
    wr(PTK_OFS_WRAP, 32'h00000000);
    wr(PTK_OFS_LIVE, 32'h00000000);
    wr(PTK_OFS_CTRL, 32'h00000003);
    n = tick_cnt;
    set_halt(1'b0);
    repeat (20) @(posedge clock);
    check(tick_cnt, n);
    rd(PTK_OFS_CTRL, v);
    check(v, 32'h00000003);
    rd(PTK_OFS_LIVE, v);
    check(v, 32'h00000000);
    // Wrap one: once in step, a tick every second cycle
    wr(PTK_OFS_WRAP, 32'h00000001);
    to_tick(n);
    to_tick(n);
    check(n, 2);
    // Reset in mid-run returns every register to zero
    wr(PTK_OFS_WRAP, 32'h00000003);
    repeat (10) @(posedge clock);
    do_reset();
    check(tick_pend, 1'b0);
    rd(PTK_OFS_CTRL, v);
    check(v, PTK_WORD_ZERO);
    rd(PTK_OFS_WRAP, v);
    check(v, PTK_WORD_ZERO);
    rd(PTK_OFS_LIVE, v);
    check(v, PTK_WORD_ZERO);
    print_verdict();
  end

endmodule // tb

`default_nettype wire
